// File: hdl/gcf_defs.svh
// Constants for the gauge CAN control framer
`ifndef GCF_DEFS_SVH
`define GCF_DEFS_SVH
`define GCF_OFS_CTRL      12'h000
`define GCF_OFS_SEL       12'h004
`define GCF_OFS_RPM       12'h008
`define GCF_OFS_STATUS    12'h00c
`define GCF_OFS_KNOCK     12'h010
`define GCF_OFS_TRIM      12'h020
`define GCF_OFS_ASSIGN    12'h040
`define GCF_OFS_VALUE     12'h080
`define GCF_RX_BASE_ID    11'd1250
`define GCF_ANALOG_ID     11'd1270
`define GCF_SW_ID_A       11'h211
`define GCF_SW_ID_B       11'h212
`define GCF_GENERIC_ID    11'h64e
`define GCF_STEP_MV       13'd650
`define GCF_HIGH_MV       16'd5000
`define GCF_RPM_MAX       14'd10000
`define GCF_SWITCH_MAX    4'd10
`define GCF_LSEL_MAX      4'd12
`define GCF_STATUS_FRAME  8'd12
`define GCF_LRPM_FRAME    8'd20
`define GCF_TRACTION_FRAME 8'd11
`define GCF_KNOCK_FRAME   8'd13
`define GCF_PERIOD_MS     50
`define GCF_CLK_HZ        40000000
`define GCF_TRIM_MV       {13'd4000, 13'd3400, 13'd3000, 13'd2500, 13'd1950, 13'd1400, 13'd700, 13'd0}
`endif

// File: hdl/gcf_pkg.sv
// Types for the gauge CAN control framer
package gcf_pkg;
    typedef enum logic [1:0] {GCF_TX_OFF = 2'b00, GCF_TX_GENERIC = 2'b01, GCF_TX_ANALOG = 2'b10,
                              GCF_TX_SWITCH = 2'b11} gcf_txmode_t;
    typedef enum logic [1:0] {GCF_RED = 2'b00, GCF_GREEN = 2'b01, GCF_YELLOW = 2'b10,
                              GCF_BLUE = 2'b11} gcf_colour_t;
    typedef enum logic [1:0] {GCF_IDLE = 2'b00, GCF_SEND_A = 2'b01, GCF_SEND_B = 2'b10} gcf_state_t;
    typedef struct packed {
        logic [10:0] id;
        logic [63:0] data;
    } gcf_frame_t;
    typedef struct packed {
        logic [7:0] frame;
        logic [2:0] slot;
    } gcf_assign_t;
endpackage

// File: hdl/gcf_framer.sv
// Gauge CAN control framer: APB registers, receive mapping, command framing
`timescale 1ns/10ps
`include "gcf_defs.svh"
module gcf_framer
    import gcf_pkg::*;
#(
    parameter int NPARAM     = 16,
    parameter int PERIOD_CYC = (`GCF_CLK_HZ / 1000) * `GCF_PERIOD_MS
)
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        rx_valid,
    input  wire gcf_frame_t  rx_frame,
    output logic             tx_valid,
    output gcf_frame_t       tx_frame,
    input  wire logic        tx_ready,
    input  wire logic        btn_up,
    input  wire logic        btn_down,
    output logic             rate_1m,
    output gcf_colour_t      status_colour,
    output logic             status_shown,
    output logic             traction_shown,
    output logic [15:0]      knock_max,
    output logic [12:0]      trim_mv
);
    localparam int PW = $clog2(NPARAM);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    gcf_txmode_t        tx_mode_reg;
    logic               rate_500k_reg;
    logic [3:0]         cal_sel_reg;
    logic [3:0]         traction_select_reg;
    logic               launch_on_reg;
    logic               antilag_on_reg;
    logic [3:0]         lsel_reg;
    logic [13:0]        rpm_reg;
    logic [12:0]        trim_reg [8];
    gcf_assign_t        assign_reg [NPARAM];
    logic [15:0]        value_reg [NPARAM];
    logic [NPARAM-1:0]  valid_reg;
    logic               wr_en;
    logic               rd_setup;
    logic [PW-1:0]      pidx;
    logic [23:0]        sel_word;

    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pidx     = paddr[PW+1:2];
    assign sel_word = {lsel_reg, 10'h000, antilag_on_reg, launch_on_reg, traction_select_reg, cal_sel_reg};

    // Reset assignment per parameter slot
    function automatic gcf_assign_t assign_rst(input int i);
        gcf_assign_t a;
        a = '{frame: 8'h00, slot: 3'h0};
        case (i)
            0: a = '{frame: `GCF_STATUS_FRAME, slot: 3'h1};
            1: a = '{frame: `GCF_LRPM_FRAME, slot: 3'h1};
            2: a = '{frame: `GCF_TRACTION_FRAME, slot: 3'h1};
            3, 4, 5, 6: a = '{frame: `GCF_KNOCK_FRAME, slot: 3'(i - 2)};
            default: a = '{frame: 8'h00, slot: 3'h0};
        endcase
        return a;
    endfunction

    // Control and selection writes; button stepping
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_mode_reg    <= GCF_TX_OFF;
            rate_500k_reg  <= 1'b0;
            cal_sel_reg    <= 4'h0;
            traction_select_reg <= 4'h0;
            launch_on_reg  <= 1'b0;
            antilag_on_reg <= 1'b0;
            lsel_reg       <= 4'h1;
            rpm_reg        <= 14'h0000;
        end
        else
        begin
            if (wr_en && paddr == `GCF_OFS_CTRL)
            begin
                tx_mode_reg   <= gcf_txmode_t'(pwdata[1:0]);
                rate_500k_reg <= pwdata[2];
            end
            if (wr_en && paddr == `GCF_OFS_SEL)
            begin
                cal_sel_reg    <= (pwdata[3:0] > `GCF_SWITCH_MAX) ? `GCF_SWITCH_MAX : pwdata[3:0];
                traction_select_reg <= (pwdata[7:4] > `GCF_SWITCH_MAX) ? `GCF_SWITCH_MAX : pwdata[7:4];
                launch_on_reg  <= pwdata[8];
                antilag_on_reg <= pwdata[9];
            end
            if (wr_en && paddr == `GCF_OFS_RPM)
                rpm_reg <= (pwdata[13:0] > `GCF_RPM_MAX) ? `GCF_RPM_MAX : pwdata[13:0];
            // Up/down stepping only in generic mode
            if (tx_mode_reg == GCF_TX_GENERIC)
            begin
                if (btn_up && !btn_down && lsel_reg < `GCF_LSEL_MAX)
                    lsel_reg <= lsel_reg + 4'h1;
                else if (btn_down && !btn_up && lsel_reg > 4'h1)
                    lsel_reg <= lsel_reg - 4'h1;
            end
        end
    end

    // Trim levels and assignments, one entry each
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_trim
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                    trim_reg[gi] <= 13'(`GCF_TRIM_MV >> (13 * gi));
                else if (wr_en && paddr == `GCF_OFS_TRIM + 12'(4 * gi))
                    trim_reg[gi] <= pwdata[12:0];
            end
        end
        for (gi = 0; gi < NPARAM; gi++)
        begin : g_param
            logic       hit;
            logic [1:0] widx;
            // Slot 4 wraps to word 3 in two bits
            assign widx = assign_reg[gi].slot[1:0] - 2'd1;
            assign hit = rx_valid && assign_reg[gi].frame != 8'h00
                         && rx_frame.id == `GCF_RX_BASE_ID + 11'(assign_reg[gi].frame) - 11'd1;
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                    assign_reg[gi] <= assign_rst(gi);
                else if (wr_en && paddr == `GCF_OFS_ASSIGN + 12'(4 * gi))
                    assign_reg[gi] <= '{frame: pwdata[7:0], slot: pwdata[10:8]};
            end
            // Slot 1..4 picks a 16-bit word
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    value_reg[gi] <= 16'h0000;
                    valid_reg[gi] <= 1'b0;
                end
                else if (assign_reg[gi].frame == 8'h00)
                    valid_reg[gi] <= 1'b0;
                else if (hit)
                begin
                    value_reg[gi] <= rx_frame.data[16 * widx +: 16];
                    valid_reg[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // APB slave: zero wait states, read data caught in setup
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (rd_setup)
            begin
                pslverr <= 1'b0;
                prdata  <= 32'h00000000;
                if (paddr == `GCF_OFS_CTRL)
                    prdata <= {29'h0, rate_500k_reg, tx_mode_reg};
                else if (paddr == `GCF_OFS_SEL)
                    prdata <= {8'h00, sel_word};
                else if (paddr == `GCF_OFS_RPM)
                    prdata <= {18'h0, rpm_reg};
                else if (paddr == `GCF_OFS_STATUS)
                    prdata <= {28'h0, traction_shown, status_shown, status_colour};
                else if (paddr == `GCF_OFS_KNOCK)
                    prdata <= {16'h0, knock_max};
                else if (paddr >= `GCF_OFS_TRIM && paddr < `GCF_OFS_ASSIGN)
                    prdata <= {19'h0, trim_reg[paddr[4:2]]};
                else if (paddr >= `GCF_OFS_ASSIGN && paddr < `GCF_OFS_ASSIGN + 12'(4 * NPARAM))
                    prdata <= {21'h0, assign_reg[pidx].slot, assign_reg[pidx].frame};
                else if (paddr >= `GCF_OFS_VALUE && paddr < `GCF_OFS_VALUE + 12'(4 * NPARAM))
                    prdata <= {15'h0, valid_reg[pidx], value_reg[pidx]};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Display side: status colour, traction, knock, trim
    // ----------------------------------------------------------------
    logic [15:0] knock_next;
    always_comb
    begin
        knock_next = 16'h0000;
        for (int k = 3; k < 7; k++)
            if (assign_reg[k].frame != 8'h00 && valid_reg[k] && value_reg[k] > knock_next)
                knock_next = value_reg[k];
    end

    // Indicator outputs follow the received parameters, assignment 2, the selected trim level and the rate bit
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            status_colour  <= GCF_RED;
            status_shown   <= 1'b0;
            traction_shown <= 1'b0;
            knock_max      <= 16'h0000;
            trim_mv        <= 13'h0000;
            rate_1m        <= 1'b1;
        end
        else
        begin
            status_colour  <= gcf_colour_t'(value_reg[0][1:0]);
            status_shown   <= valid_reg[0];
            traction_shown <= assign_reg[2].frame != 8'h00;
            knock_max      <= knock_next;
            trim_mv        <= trim_reg[cal_sel_reg[2:0]];
            rate_1m        <= !rate_500k_reg;
        end
    end

    // ----------------------------------------------------------------
    // Command framing
    // ----------------------------------------------------------------
    gcf_state_t  state_reg;
    logic [31:0] timer_reg;
    logic [23:0] sent_reg;
    logic [3:0]  traction_eff;
    logic [2:0]  cal_step;
    logic [2:0]  traction_step;
    gcf_frame_t  frame_a;
    gcf_frame_t  frame_b;
    logic        due;

    assign traction_eff  = (assign_reg[2].frame == 8'h00) ? 4'h0 : traction_select_reg;
    assign cal_step      = (cal_sel_reg > 4'd7) ? 3'd7 : cal_sel_reg[2:0];
    assign traction_step = (traction_eff > 4'd7) ? 3'd7 : traction_eff[2:0];
    assign due           = timer_reg == 32'(PERIOD_CYC - 1) || sel_word != sent_reg;

    // Frame contents per transmit mode
    always_comb
    begin
        frame_a = '{id: `GCF_GENERIC_ID, data: 64'h0};
        frame_b = '{id: `GCF_SW_ID_B, data: 64'h0};
        case (tx_mode_reg)
            GCF_TX_GENERIC:
                frame_a.data = {16'h0, 4'h0, lsel_reg, 8'h00, 4'h0, traction_eff, 4'h0, cal_sel_reg,
                                7'h0, launch_on_reg, 7'h0, antilag_on_reg};
            GCF_TX_ANALOG:
            begin
                frame_a.id   = `GCF_ANALOG_ID;
                frame_a.data = {3'h0, 13'(traction_step * `GCF_STEP_MV),
                                antilag_on_reg ? `GCF_HIGH_MV : 16'h0000,
                                launch_on_reg ? `GCF_HIGH_MV : 16'h0000,
                                3'h0, 13'(cal_step * `GCF_STEP_MV)};
            end
            GCF_TX_SWITCH:
            begin
                frame_a.id   = `GCF_SW_ID_A;
                frame_a.data = {16'h0000, 2'h0, rpm_reg, 12'h000, traction_eff, 12'h000, cal_sel_reg};
                frame_b.data = {32'h0, 15'h0, antilag_on_reg, 15'h0, launch_on_reg};
            end
            default: frame_a = '{id: `GCF_GENERIC_ID, data: 64'h0};
        endcase
    end

    // Period timer restarts on each send
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            timer_reg <= 32'h0;
        else if (state_reg == GCF_IDLE && due)
            timer_reg <= 32'h0;
        else if (timer_reg != 32'(PERIOD_CYC - 1))
            timer_reg <= timer_reg + 32'h1;
    end

    // Transmit sequencer with ready handshake
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= GCF_IDLE;
            tx_valid  <= 1'b0;
            tx_frame  <= '{id: 11'h0, data: 64'h0};
            sent_reg  <= 24'h0;
        end
        else
        begin
            case (state_reg)
                GCF_IDLE:
                    if (due)
                    begin
                        sent_reg <= sel_word;
                        if (tx_mode_reg != GCF_TX_OFF)
                        begin
                            tx_valid  <= 1'b1;
                            tx_frame  <= frame_a;
                            state_reg <= GCF_SEND_A;
                        end
                    end
                GCF_SEND_A:
                    if (tx_ready)
                    begin
                        if (tx_mode_reg == GCF_TX_SWITCH)
                        begin
                            tx_frame  <= frame_b;
                            state_reg <= GCF_SEND_B;
                        end
                        else
                        begin
                            tx_valid  <= 1'b0;
                            state_reg <= GCF_IDLE;
                        end
                    end
                GCF_SEND_B:
                    if (tx_ready)
                    begin
                        tx_valid  <= 1'b0;
                        state_reg <= GCF_IDLE;
                    end
                default: state_reg <= GCF_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    status_colour_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ##1 status_colour == $past(value_reg[0][1:0])) else $error("status colour wrong");
    disabled_hidden_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        assign_reg[0].frame == 8'h00 |=> !valid_reg[0]) else $error("disabled parameter valid");
    traction_hide_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        assign_reg[2].frame == 8'h00 |=> !traction_shown) else $error("traction shown while off");
    launch_range_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        lsel_reg >= 4'h1 && lsel_reg <= `GCF_LSEL_MAX) else $error("launch select out of range");
    analog_id_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == GCF_IDLE && due && tx_mode_reg == GCF_TX_ANALOG |=> tx_frame.id == `GCF_ANALOG_ID)
        else $error("analog id");
    analog_step_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(tx_valid) && tx_frame.id == `GCF_ANALOG_ID |-> tx_frame.data[15:0] <= 16'd4550)
        else $error("analog step too high");
    switch_pair_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == GCF_SEND_A && tx_ready && tx_mode_reg == GCF_TX_SWITCH
        |=> tx_valid && tx_frame.id == `GCF_SW_ID_B) else $error("second switch frame missing");
    tx_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame)) else $error("frame dropped");
    change_send_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == GCF_IDLE && sel_word != sent_reg && tx_mode_reg != GCF_TX_OFF |=> tx_valid)
        else $error("change not sent");
    rpm_range_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rpm_reg <= `GCF_RPM_MAX && cal_sel_reg <= `GCF_SWITCH_MAX) else $error("range exceeded");
    off_silent_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == GCF_IDLE && tx_mode_reg == GCF_TX_OFF |=> !tx_valid) else $error("frame sent while off");
    lsel_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        tx_mode_reg != GCF_TX_GENERIC |=> $stable(lsel_reg)) else $error("launch select moved");
    rate_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ##1 rate_1m == !$past(rate_500k_reg)) else $error("rate output wrong");
endmodule

// File: verification/gcf_ecu_model.sv
// Engine controller model facing the framer's CAN side
`timescale 1ns/10ps
module gcf_ecu_model
    import gcf_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       tx_valid,
    input  wire gcf_frame_t tx_frame,
    output logic            tx_ready,
    output logic            rx_valid,
    output gcf_frame_t      rx_frame
);
    int          rdy_wait = 0;
    int          wait_cnt;
    int          acc_cnt;
    gcf_frame_t  last_frame;
    logic [10:0] prev_id;

    // Idle line levels before the first frame
    initial
    begin
        rx_valid = 1'b0;
        rx_frame = '0;
    end

    // Sends one data frame from the sequential identifier range
    task automatic send(input logic [10:0] id, input logic [63:0] data);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_frame <= {id, data};
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_frame <= ~{id, data}; // Stale value never looks valid
    endtask

    // Accepts every command frame after a programmable stall
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_ready <= 1'b0;
            wait_cnt <= 0;
            acc_cnt  <= 0;
        end
        else if (tx_valid && tx_ready)
        begin
            tx_ready   <= 1'b0;
            wait_cnt   <= 0;
            acc_cnt    <= acc_cnt + 1;
            prev_id    <= last_frame.id;
            last_frame <= tx_frame;
        end
        else if (tx_valid)
        begin
            if (wait_cnt >= rdy_wait)
                tx_ready <= 1'b1;
            else
                wait_cnt <= wait_cnt + 1;
        end
    end
endmodule

// File: verification/gauge_can_control_framer_tb.sv
// Self-checking bench for the gauge CAN control framer
`timescale 1ns/10ps
`include "gcf_defs.svh"
module gauge_can_control_framer_tb
    import gcf_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        resetn, psel, penable, pwrite, pready, pslverr, rx_valid;
    logic        tx_valid, tx_ready, btn_up, btn_down, rate_1m, status_shown, traction_shown;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    gcf_frame_t  rx_frame, tx_frame;
    gcf_colour_t status_colour;
    logic [15:0] knock_max;
    logic [12:0] trim_mv;
    logic        rerr;
    int          failures = 0;
    int          compares = 0;
    int          c0;
    logic [12:0] tv [8] = '{13'h0, 13'h2bc, 13'h578, 13'h79e, 13'h9c4, 13'hbb8, 13'hd48, 13'hfa0};

    always #12.5 clk_sys = ~clk_sys;

    gcf_framer #(.NPARAM(16), .PERIOD_CYC(64)) gcf_framer_i (
        .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_ready(tx_ready), .btn_up(btn_up), .btn_down(btn_down), .rate_1m(rate_1m),
        .status_colour(status_colour), .status_shown(status_shown), .traction_shown(traction_shown),
        .knock_max(knock_max), .trim_mv(trim_mv));

    gcf_ecu_model ecu_i (
        .clk_sys(clk_sys), .resetn(resetn), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame(rx_frame));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (n == 50)
        begin
            chk("apb timeout", 1, 0);
            tally_and_finish();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("apb read", rdat, e);
    endtask

    // Waits for n accepted command frames carrying the given identifier
    task automatic wait_frame(input logic [10:0] id, input int n);
        int c;
        int k;
        c = ecu_i.acc_cnt;
        k = 0;
        for (int t = 0; t < 3000 && k < n; t++)
        begin
            @(posedge clk_sys);
            if (ecu_i.acc_cnt != c)
            begin
                c = ecu_i.acc_cnt;
                if (ecu_i.last_frame.id === id)
                    k++;
            end
        end
        if (k < n)
        begin
            chk("frame timeout", 1, 0);
            tally_and_finish();
        end
    endtask

    task automatic pulse(input logic up);
        @(posedge clk_sys);
        btn_up <= up;
        btn_down <= !up;
        @(posedge clk_sys);
        btn_up <= 1'b0;
        btn_down <= 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        resetn = 1'b0;
        {psel, penable, pwrite, btn_up, btn_down} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge clk_sys);
        chk("rate reset", rate_1m, 1);
        resetn <= 1'b1;
        rd(`GCF_OFS_ASSIGN, 32'h10c);
        rd(`GCF_OFS_ASSIGN + 12'h4, 32'h114);
        for (int i = 7; i < 16; i++) rd(`GCF_OFS_ASSIGN + 12'(4 * i), 32'h0);
        for (int i = 0; i < 8; i++) rd(`GCF_OFS_TRIM + 12'(4 * i), 32'(tv[i]));
        rd(12'h0f0, 32'h0);
        chk("unmapped err", rerr, 1);
        for (int s = 0; s < 4; s++)
        begin
            ecu_i.send(11'h4ed, 64'(s));
            repeat (3) @(posedge clk_sys);
            chk("colour", status_colour, s);
        end
        ecu_i.send(11'h4ee, 64'h0028_001e_0014_000a);
        repeat (3) @(posedge clk_sys);
        chk("knock all", knock_max, 16'h28);
        rd(`GCF_OFS_VALUE + 12'hc, 32'h1000a);
        apb(1'b1, `GCF_OFS_ASSIGN + 12'h18, 32'h0);
        ecu_i.send(11'h4ee, 64'h0028_001e_0014_000a);
        repeat (3) @(posedge clk_sys);
        chk("knock masked", knock_max, 16'h1e);
        apb(1'b1, `GCF_OFS_ASSIGN, 32'h0);
        ecu_i.send(11'h4ed, 64'h1);
        repeat (3) @(posedge clk_sys);
        chk("status off", status_shown, 0);
        chk("traction on", traction_shown, 1);
        ecu_i.rdy_wait = 5;
        apb(1'b1, `GCF_OFS_RPM, 32'h2ee0);
        apb(1'b1, `GCF_OFS_SEL, 32'h17a);
        apb(1'b1, `GCF_OFS_CTRL, 32'h3);
        wait_frame(11'h211, 2);
        chk("frame a", ecu_i.last_frame.data, 64'h0000_2710_0007_000a);
        wait_frame(11'h212, 1);
        chk("pair order", ecu_i.prev_id, 11'h211);
        chk("frame b", ecu_i.last_frame.data, 64'h1);
        chk("recv window", {ecu_i.last_frame.id[10:4], 4'h0}, 11'd528);
        apb(1'b1, `GCF_OFS_ASSIGN + 12'h8, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("traction off", traction_shown, 0);
        wait_frame(11'h211, 2);
        chk("frame a no traction", ecu_i.last_frame.data, 64'h0000_2710_0000_000a);
        ecu_i.rdy_wait = 0;
        apb(1'b1, `GCF_OFS_ASSIGN + 12'h8, 32'h10b);
        apb(1'b1, `GCF_OFS_SEL, 32'h193);
        apb(1'b1, `GCF_OFS_CTRL, 32'h2);
        wait_frame(`GCF_ANALOG_ID, 2);
        chk("analog", ecu_i.last_frame.data, 64'h11c6_0000_1388_079e);
        chk("trim", trim_mv, 13'h79e);
        apb(1'b1, `GCF_OFS_SEL, 32'h293);
        wait_frame(`GCF_ANALOG_ID, 2);
        chk("analog alt", ecu_i.last_frame.data, 64'h11c6_1388_0000_079e);
        c0 = ecu_i.acc_cnt;
        repeat (200) @(posedge clk_sys);
        chk("periodic", ecu_i.acc_cnt - c0 >= 2, 1);
        apb(1'b1, `GCF_OFS_CTRL, 32'h1);
        repeat (13) pulse(1'b1);
        rd(`GCF_OFS_SEL, 32'h00c0_0293);
        wait_frame(11'h64e, 2);
        chk("launch sel", ecu_i.last_frame.data[47:40], 8'hc);
        repeat (13) pulse(1'b0);
        rd(`GCF_OFS_SEL, 32'h0010_0293);
        apb(1'b1, `GCF_OFS_CTRL, 32'h4);
        repeat (70) @(posedge clk_sys);
        chk("rate alt", rate_1m, 0);
        c0 = ecu_i.acc_cnt;
        repeat (200) @(posedge clk_sys);
        chk("off silent", ecu_i.acc_cnt - c0, 0);
        tally_and_finish();
    end
endmodule
